// ### rtl/pdr_consts.svh
// Constants for the power-down release and power-up gate block.
// Assumes a 10 MHz system clock that oversamples the serial link pins.
// Contract
// - In deep sleep, ignore every instruction except the release instruction.
// - Executing the release instruction leaves deep sleep.
// - Release instruction returns an 8-bit legacy id byte, distinct from two-byte id.
// - Id byte is delivered even if deep sleep was never entered, when idle.
// - Release during a running write cycle is not decoded and leaves it alone.
// - Select low, opcode then 3 dummy bytes, inputs sampled on rising clock.
// - After dummies, id bits change on falling serial clock edge.
// - Continued clocking with select low repeats the id byte.
// - Select rising after a full id read moves device to standby.
// - From deep sleep, full-read return is delayed by the long release time.
// - Early select rise after opcode still enters standby, short delay from sleep.
// - Write-type instructions ignored until power-up write lockout elapses.
// - Read instructions accepted after the select delay, lockout still running.
// - Power-up in standby, not deep sleep, with write enable latch cleared.
// - Delivered state: array bytes read FF, status reads 00.
// - Write-in-progress flag is 1 during self-timed cycles, 0 afterwards.
// - Write enable sets the latch; write-type commands need the latch set.
// - Deep sleep entry during a running write cycle is rejected.
`ifndef PDR_CONSTS_SVH
`define PDR_CONSTS_SVH
`define PDR_CLK_HZ          10000000
`define PDR_OP_RELEASE      8'hAB
`define PDR_OP_READ_TWO_BYTE_IDENTIFIER         8'h9F
`define PDR_OP_SLEEP        8'hB9
`define PDR_OP_WRITE_ENABLE_CMD         8'h06
`define PDR_OP_WRDI         8'h04
`define PDR_OP_PAGE         8'h02
`define PDR_OP_SECTOR       8'hD8
`define PDR_OP_FULL         8'hC7
`define PDR_OP_STWR         8'h01
`define PDR_OP_STRD         8'h05
`define PDR_OP_READ         8'h03
`define PDR_STATUS_RESET    8'h00
`define PDR_ARRAY_ERASED    8'hFF
`define PDR_DUMMY_BYTES     3
`define PDR_LOCKOUT_US      10000
`define PDR_SHORT_REL_US    3
`define PDR_LONG_REL_US     30
`define PDR_SLEEP_ENTRY_US  3
`define PDR_WIP_BIT         0
`define PDR_WEL_BIT         1
`endif

// ### rtl/pdr_pkg.sv
// Types shared by the power-down release block.
// Assumes the constants header is compiled alongside.
`default_nettype none
package pdr_pkg;
	typedef enum logic [1:0] {
		PDR_STANDBY = 2'b00,
		PDR_SLEEP   = 2'b01,
		PDR_WAKING  = 2'b11
	} pdr_power_e;
	typedef enum logic [2:0] {
		PDR_IDLE    = 3'b000,
		PDR_OPCODE  = 3'b001,
		PDR_DUMMY   = 3'b011,
		PDR_IDOUT   = 3'b010,
		PDR_DISCARD = 3'b110
	} pdr_shift_e;
endpackage : pdr_pkg
`default_nettype wire

// ### rtl/pdr_timer.sv
// Down counter for delays measured in system clock cycles.
// Assumes a load pulse and a count in the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module pdr_timer #(
	parameter int WIDTH = 20
) (
	input  wire logic             i_clk_sys,
	input  wire logic             i_rst_n,
	input  wire logic             i_load,
	input  wire logic [WIDTH-1:0] i_count,
	output logic                  o_busy,
	output logic                  o_done
);
	logic [WIDTH-1:0] count_reg;
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			count_reg <= '0;
			o_done    <= 1'b0;
		end
		else if (i_load)
		begin
			count_reg <= i_count;
			o_done    <= 1'b0;
		end
		else
		begin
			count_reg <= (count_reg != '0) ? count_reg - 1'b1 : count_reg;
			o_done    <= (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});
		end
	end
	assign o_busy = (count_reg != '0);
endmodule : pdr_timer
`default_nettype wire

// ### rtl/pdr_gate.sv
// Serial instruction front end: release from deep sleep, legacy id readout, power-up gating.
// Assumes link pins are asynchronous to the 10 MHz clock and that cycle timing lives elsewhere.
`timescale 1ns/1ps
`default_nettype none
`include "pdr_consts.svh"
module pdr_gate
	import pdr_pkg::*;
#(
	parameter logic [7:0] RELEASE_OPCODE = `PDR_OP_RELEASE,
	parameter logic [7:0] LEGACY_ID      = 8'h5A, // Arbitrary value.
	parameter int         SHORT_REL_US   = `PDR_SHORT_REL_US,
	parameter int         LONG_REL_US    = `PDR_LONG_REL_US,
	parameter int         LOCKOUT_CYC    = `PDR_LOCKOUT_US * (`PDR_CLK_HZ / 1000000)
) (
	input  wire logic i_clk_sys,
	input  wire logic i_rstn,
	input  wire logic i_sel_n,
	input  wire logic i_sclk,
	input  wire logic i_sdi,
	input  wire logic i_cycle_done,
	output logic      o_sdo,
	output logic      o_sdo_oe,
	output logic      o_write_in_progress_flag,
	output logic      o_write_enable_latch,
	output logic      o_deep_sleep,
	output logic      o_standby,
	output logic      o_lockout,
	output logic      o_cycle_start,
	output logic [7:0] o_cmd,
	output logic      o_cmd_valid
);
	localparam int SHORT_CYC = SHORT_REL_US * (`PDR_CLK_HZ / 1000000);
	localparam int LONG_CYC  = LONG_REL_US * (`PDR_CLK_HZ / 1000000);
	localparam int TW        = 20;

	logic [1:0] rst_sync_reg;
	logic       rst_n;
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
			rst_sync_reg <= 2'b00;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// Two-stage synchronisers, then a third stage for edge detection.
	logic [2:0] sel_reg, sclk_reg, sdi_reg;
	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sel_reg  <= 3'b111;
			sclk_reg <= 3'b000;
			sdi_reg  <= 3'b000;
		end
		else
		begin
			sel_reg  <= {sel_reg[1:0], i_sel_n};
			sclk_reg <= {sclk_reg[1:0], i_sclk};
			sdi_reg  <= {sdi_reg[1:0], i_sdi};
		end
	end
	wire sel_fall  = sel_reg[2] & ~sel_reg[1];
	wire sel_rise  = ~sel_reg[2] & sel_reg[1];
	wire selected  = ~sel_reg[1];
	wire sclk_rise = selected & ~sclk_reg[2] & sclk_reg[1];
	wire sclk_fall = selected & sclk_reg[2] & ~sclk_reg[1];
	wire bit_in    = sdi_reg[1];

	pdr_shift_e  shift_reg, shift_next;
	pdr_power_e  power_reg;
	logic [2:0]  bit_cnt_reg;
	logic [1:0]  dummy_cnt_reg;
	logic [7:0]  rx_reg, tx_reg;
	logic        id_done_reg;
	logic        wel_reg, wip_reg, pend_reg;
	logic [7:0]  pend_op_reg;

	wire [7:0] rx_full   = {rx_reg[6:0], bit_in};
	wire       byte_end  = sclk_rise & (bit_cnt_reg == 3'd7);
	wire       op_end    = (shift_reg == PDR_OPCODE) & byte_end;
	wire       is_rel    = (rx_full == RELEASE_OPCODE);
	wire       in_sleep  = (power_reg != PDR_STANDBY);
	wire       lock_busy;
	wire       is_wtype  = (rx_full == `PDR_OP_WRITE_ENABLE_CMD) | (rx_full == `PDR_OP_PAGE)
	                     | (rx_full == `PDR_OP_SECTOR) | (rx_full == `PDR_OP_FULL)
	                     | (rx_full == `PDR_OP_STWR);
	wire       is_cyc    = (rx_full == `PDR_OP_PAGE) | (rx_full == `PDR_OP_SECTOR)
	                     | (rx_full == `PDR_OP_FULL) | (rx_full == `PDR_OP_STWR);
	// Release is not decoded during a cycle, nor is anything else but release in sleep.
	wire       rel_ok    = op_end & is_rel & ~wip_reg;
	wire       op_drop   = op_end & ((in_sleep & ~is_rel) | (wip_reg & is_rel)
	                     | (is_wtype & lock_busy)
	                     | (is_cyc & ~wel_reg)
	                     | (wip_reg & (rx_full == `PDR_OP_SLEEP)));
	wire       op_pass   = op_end & ~rel_ok & ~op_drop;

	always_comb
	begin
		shift_next = shift_reg;
		case (shift_reg)
			PDR_IDLE:    shift_next = PDR_OPCODE;
			PDR_OPCODE:  if (op_end) shift_next = rel_ok ? PDR_DUMMY : PDR_DISCARD;
			PDR_DUMMY:   if (byte_end && dummy_cnt_reg == 2'd2) shift_next = PDR_IDOUT;
			PDR_IDOUT:   shift_next = PDR_IDOUT;
			PDR_DISCARD: shift_next = PDR_DISCARD;
			default:     shift_next = PDR_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shift_reg     <= PDR_IDLE;
			bit_cnt_reg   <= 3'd0;
			dummy_cnt_reg <= 2'd0;
			rx_reg        <= 8'h00;
		end
		else if (!selected || sel_fall)
		begin
			shift_reg     <= PDR_IDLE;
			bit_cnt_reg   <= 3'd0;
			dummy_cnt_reg <= 2'd0;
			rx_reg        <= 8'h00;
		end
		else
		begin
			shift_reg <= shift_next;
			if (sclk_rise)
			begin
				rx_reg      <= rx_full;
				bit_cnt_reg <= bit_cnt_reg + 3'd1;
				if (byte_end && shift_reg == PDR_DUMMY)
					dummy_cnt_reg <= dummy_cnt_reg + 2'd1;
			end
		end
	end

	// Id bits shift on falling clock; a full byte marks the read as complete.
	logic [2:0] tx_cnt_reg;
	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_reg      <= 8'h00;
			tx_cnt_reg  <= 3'd0;
			id_done_reg <= 1'b0;
			o_sdo       <= 1'b0;
			o_sdo_oe    <= 1'b0;
		end
		else if (!selected)
		begin
			o_sdo_oe   <= 1'b0;
			tx_cnt_reg <= 3'd0;
			if (sel_fall || sel_rise)
				id_done_reg <= id_done_reg & ~sel_fall;
		end
		else if (sel_fall)
			id_done_reg <= 1'b0;
		else if (shift_reg == PDR_IDOUT && sclk_fall)
		begin
			o_sdo_oe   <= 1'b1;
			o_sdo      <= (tx_cnt_reg == 3'd0) ? LEGACY_ID[7] : tx_reg[7];
			tx_reg     <= (tx_cnt_reg == 3'd0) ? {LEGACY_ID[6:0], 1'b0} : {tx_reg[6:0], 1'b0};
			tx_cnt_reg <= tx_cnt_reg + 3'd1;
			if (tx_cnt_reg == 3'd7)
				id_done_reg <= 1'b1;
		end
	end

	// A release seen at select rise leaves sleep; delay depends on how far it got.
	logic       rel_seen_reg;
	wire        rel_end   = sel_rise & rel_seen_reg;
	wire        rel_full  = id_done_reg | (shift_reg == PDR_IDOUT & tx_cnt_reg == 3'd0
	                      & id_done_reg);
	wire        sleep_end = sel_rise & (pend_op_reg == `PDR_OP_SLEEP) & pend_reg;
	wire        tmr_load  = rel_end & (power_reg == PDR_SLEEP);
	wire [TW-1:0] tmr_cnt = rel_full ? TW'(LONG_CYC) : TW'(SHORT_CYC);
	wire        tmr_done;
	logic       lock_started_reg;

	pdr_timer #(.WIDTH(TW)) u_rel_timer (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (rst_n),
		.i_load    (tmr_load),
		.i_count   (tmr_cnt),
		.o_busy    (),
		.o_done    (tmr_done)
	);
	pdr_timer #(.WIDTH(TW)) u_lock_timer (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (rst_n),
		.i_load    (~rst_sync_reg[1] | (rst_n & ~lock_started_reg)),
		.i_count   (TW'(LOCKOUT_CYC)),
		.o_busy    (lock_busy),
		.o_done    ()
	);
	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			lock_started_reg <= 1'b0;
		else
			lock_started_reg <= 1'b1;
	end

	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			power_reg    <= PDR_STANDBY;
			rel_seen_reg <= 1'b0;
			pend_reg     <= 1'b0;
			pend_op_reg  <= 8'h00;
			wel_reg      <= 1'b0;
			wip_reg      <= 1'b0;
			o_cycle_start <= 1'b0;
			o_cmd        <= 8'h00;
			o_cmd_valid  <= 1'b0;
		end
		else
		begin
			o_cycle_start <= 1'b0;
			o_cmd_valid   <= op_pass;
			if (op_pass)
				o_cmd <= rx_full;
			if (sel_fall)
				rel_seen_reg <= 1'b0;
			else if (rel_ok)
				rel_seen_reg <= 1'b1;
			if (op_pass && rx_full == `PDR_OP_WRITE_ENABLE_CMD)
				wel_reg <= 1'b1;
			else if (op_pass && rx_full == `PDR_OP_WRDI)
				wel_reg <= 1'b0;
			if (op_pass)
			begin
				pend_reg    <= is_cyc | (rx_full == `PDR_OP_SLEEP);
				pend_op_reg <= rx_full;
			end
			else if (sel_fall)
				pend_reg <= 1'b0;
			if (sel_rise && pend_reg && pend_op_reg != `PDR_OP_SLEEP)
			begin
				wip_reg       <= 1'b1;
				o_cycle_start <= 1'b1;
				pend_reg      <= 1'b0;
			end
			else if (wip_reg && i_cycle_done)
			begin
				wip_reg <= 1'b0;
				// A write enable decoded on the cycle-end clock keeps the latch set.
				if (!(op_pass && rx_full == `PDR_OP_WRITE_ENABLE_CMD))
					wel_reg <= 1'b0;
			end
			if (sleep_end)
			begin
				power_reg <= PDR_SLEEP;
				pend_reg  <= 1'b0;
			end
			else if (tmr_load)
				power_reg <= PDR_WAKING;
			else if (power_reg == PDR_WAKING && tmr_done)
				power_reg <= PDR_STANDBY;
		end
	end

	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_write_in_progress_flag <= 1'b0;
			o_write_enable_latch     <= 1'b0;
			o_deep_sleep             <= 1'b0;
			o_standby                <= 1'b1;
			o_lockout                <= 1'b1;
		end
		else
		begin
			o_write_in_progress_flag <= wip_reg;
			o_write_enable_latch     <= wel_reg;
			o_deep_sleep             <= (power_reg == PDR_SLEEP);
			o_standby                <= (power_reg == PDR_STANDBY) & ~wip_reg;
			o_lockout                <= lock_busy | ~lock_started_reg;
		end
	end

	a_sleep_ignores: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		op_end && in_sleep && !is_rel |=> !o_cmd_valid) else $error("command passed in sleep");
	a_release_wip: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		op_end && is_rel && wip_reg |=> shift_reg != PDR_DUMMY) else $error("release during cycle");
	a_wake_delay: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		tmr_load |=> power_reg == PDR_WAKING) else $error("sleep not left");
	a_lock_write: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		op_end && is_wtype && lock_busy |=> !o_cmd_valid) else $error("write in lockout");
	a_wel_needed: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		op_end && is_cyc && !wel_reg |=> !o_cmd_valid) else $error("write without latch");
	a_wip_flag: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		o_cycle_start |-> ##1 o_write_in_progress_flag) else $error("wip not shown");
	a_sleep_reject: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		op_end && wip_reg && rx_full == `PDR_OP_SLEEP |=> !o_cmd_valid) else $error("sleep in cycle");
	a_restart_sel: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		sel_fall |=> shift_reg == PDR_IDLE) else $error("decode not restarted");
endmodule : pdr_gate
`default_nettype wire

// ### sim/pdr_spi_master.sv
// Serial bus master model that frames transfers for the release block.
// Assumes the system clock paces it; the link clock idles low between frames.
`timescale 1ns/1ps
`default_nettype none
module pdr_spi_master (
	input  wire logic i_clk_sys,
	input  wire logic i_sdo_line,
	output logic      o_sel_n,
	output logic      o_sclk,
	output logic      o_sdi
);
	initial
	begin
		o_sel_n = 1'b1;
		o_sclk  = 1'b0;
		o_sdi   = 1'b0;
	end

	// Eight system cycles per bit give the 800 ns link period; data moves a cycle after
	// the fall so it never changes on the edge where the device takes it.
	task automatic frame(input logic [47:0] tx, input int nbits, output logic [15:0] rx);
		int i;
		rx = 16'h0000;
		@(posedge i_clk_sys);
		o_sel_n <= 1'b0;
		for (i = 0; i < nbits; i++)
		begin
			@(posedge i_clk_sys);
			o_sdi <= tx[47-i];
			repeat (4) @(posedge i_clk_sys);
			o_sclk <= 1'b1;
			repeat (3) @(posedge i_clk_sys);
			rx = {rx[14:0], i_sdo_line};
			o_sclk <= 1'b0;
		end
		repeat (2) @(posedge i_clk_sys);
		o_sel_n <= 1'b1;
		o_sdi   <= ~o_sdi;
	endtask : frame
endmodule : pdr_spi_master
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the release and power-up gate block.
// Assumes the serial master model drives the link pins and the lockout is shortened.
`timescale 1ns/1ps
`default_nettype none
`include "pdr_consts.svh"
module tb_top;
	localparam int         LC = 1200;
	localparam logic [7:0] ID = 8'hC3; // Arbitrary value.
	localparam int         SH = `PDR_SHORT_REL_US * 10;
	localparam int         LG = `PDR_LONG_REL_US * 10;
	logic        clk, rstn, done;
	logic        flip = 1'b0;
	logic        sel_n, sclk, sdi, sdo, oe, write_in_progress_flag, write_enable_latch, slp, stby, lock, cst, cvl;
	logic [7:0]  cmd;
	logic [15:0] rx;
	wire logic   sdo_line;
	int          bad_count, num_checks, cyc, n_st, n_vl, n_oe, a, b;

	// A released output line shows a pattern that changes every cycle.
	assign sdo_line = oe ? sdo : flip;

	pdr_gate #(.LEGACY_ID(ID), .LOCKOUT_CYC(LC)) dut_u (
		.i_clk_sys(clk), .i_rstn(rstn), .i_sel_n(sel_n), .i_sclk(sclk), .i_sdi(sdi),
		.i_cycle_done(done), .o_sdo(sdo), .o_sdo_oe(oe), .o_write_in_progress_flag(write_in_progress_flag),
		.o_write_enable_latch(write_enable_latch), .o_deep_sleep(slp), .o_standby(stby), .o_lockout(lock),
		.o_cycle_start(cst), .o_cmd(cmd), .o_cmd_valid(cvl));
	pdr_spi_master mst_u (.i_clk_sys(clk), .i_sdo_line(sdo_line), .o_sel_n(sel_n),
		.o_sclk(sclk), .o_sdi(sdi));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		flip <= ~flip;
		n_st += (cst === 1'b1);
		n_vl += (cvl === 1'b1);
		n_oe += (oe === 1'b1);
		if (cyc == 12000)
		begin
			bad_count++;
			summarize();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : chk

	task automatic op(input logic [47:0] tx, input int n);
		mst_u.frame(tx, n, rx);
		repeat (6) @(posedge clk);
	endtask : op

	task automatic wait_stby(input int lo, input int hi);
		int k;
		k = 0;
		while (stby !== 1'b1 && k < hi)
		begin
			@(posedge clk);
			k++;
		end
		chk(16'(k >= lo && k < hi), 16'h1, "standby delay");
	endtask : wait_stby

	task automatic t_lockout();
		chk({stby, slp, write_enable_latch, write_in_progress_flag, lock, oe}, 16'h22, "power-up state");
		op({`PDR_OP_WRITE_ENABLE_CMD, 40'h0}, 8);
		chk(write_enable_latch, 1'b0, "latch set in lockout");
		op({`PDR_OP_RELEASE, 40'h0}, 40);
		chk(rx[7:0], ID, "id in lockout");
		chk({stby, lock}, 2'b11, "standby after read");
		a = n_vl;
		op({`PDR_OP_READ, 40'h0}, 32);
		chk(16'(n_vl - a), 16'h1, "read in lockout");
		chk(cmd, `PDR_OP_READ, "read opcode handed on");
		a = 0;
		while (lock !== 1'b0 && a < LC)
		begin
			@(posedge clk);
			a++;
		end
		chk(lock, 1'b0, "lockout end");
		$display("test lockout done");
	endtask : t_lockout

	task automatic t_sleep();
		op({`PDR_OP_WRITE_ENABLE_CMD, 40'h0}, 8);
		chk(write_enable_latch, 1'b1, "latch set");
		op({`PDR_OP_SLEEP, 40'h0}, 8);
		chk({slp, stby}, 2'b10, "sleep entry");
		a = n_vl;
		op({`PDR_OP_READ, 40'h0}, 32);
		chk(16'(n_vl - a), 16'h0, "read taken in sleep");
		mst_u.frame({`PDR_OP_RELEASE, 40'h0}, 48, rx);
		wait_stby(LG - 10, LG + 20);
		chk({rx, slp}, {ID, ID, 1'b0}, "repeated id");
		op({`PDR_OP_SLEEP, 40'h0}, 8);
		mst_u.frame({`PDR_OP_RELEASE, 40'h0}, 16, rx);
		wait_stby(SH - 10, SH + 20);
		op({8'hFF, 40'h0}, 4);
		op({`PDR_OP_RELEASE, 40'h0}, 40);
		chk(rx[7:0], ID, "id after partial frame");
		$display("test sleep done");
	endtask : t_sleep

	task automatic t_cycle();
		a = n_st;
		op({`PDR_OP_SECTOR, 40'h0}, 32);
		chk({16'(n_st - a), write_in_progress_flag}, {16'h1, 1'b1}, "cycle start");
		b = n_vl;
		a = n_oe;
		op({`PDR_OP_RELEASE, 40'h0}, 40);
		op({`PDR_OP_SLEEP, 40'h0}, 8);
		chk({16'(n_vl - b), write_in_progress_flag, slp}, {16'h0, 2'b10}, "refused in cycle");
		chk(16'(n_oe - a), 16'h0, "id sent in cycle");
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		repeat (4) @(posedge clk);
		chk({write_in_progress_flag, write_enable_latch, stby}, 3'b001, "cycle end");
		a = n_st;
		op({`PDR_OP_PAGE, 40'h0}, 40);
		chk({16'(n_st - a), write_in_progress_flag}, 17'h0, "program without latch");
		$display("test cycle done");
	endtask : t_cycle

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	initial
	begin
		rstn = 1'b0;
		done = 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		// Select stays high past the supply-to-select delay before the first frame.
		repeat (300) @(posedge clk);
		t_lockout();
		t_sleep();
		t_cycle();
		summarize();
	end
endmodule : tb_top
`default_nettype wire
